// ===== mmcs_pkg.sv
// Purpose: shared constants and carrier types of the module management control block
// Assumes: 40 MHz system clock; byte offsets of the management map are 8-bit
// Notes:   management map layout lives here

package mmcs_pkg;

   // ==========================================================
   // clock and timing
   localparam int CLK_FREQ_HZ      = 40_000_000;
   localparam int CYCLES_PER_MS    = CLK_FREQ_HZ / 1000;
   // longest initialisation time, in ms
   localparam int T_INIT_MS        = 2000;
   localparam int INIT_MAX_CYCLES  = T_INIT_MS * CYCLES_PER_MS;
   // shortest reset pulse, in us, rounded up
   localparam int T_RESET_MIN_US   = 2;
   localparam int RESET_MIN_CYCLES = (T_RESET_MIN_US * CYCLES_PER_MS + 999) / 1000;
   // strictly longer than the minimum
   localparam int RESET_HOLD_CYCLES = RESET_MIN_CYCLES + 1;
   // real init delay, far inside the maximum
   localparam int INIT_DEFAULT_CYCLES = 1024;

   // ==========================================================
   // management map
   localparam logic [6:0] DEV_ADDR      = 7'h50;
   localparam logic [7:0] ADDR_STATUS   = 8'h02;
   localparam int         DNR_BIT       = 0;
   localparam logic [7:0] ADDR_FLAG_LOS = 8'h03;
   localparam logic [7:0] ADDR_FLAG_TXF = 8'h04;
   localparam logic [7:0] ADDR_FLAG_RDY = 8'h05;
   localparam logic [7:0] ADDR_CTRL_PWR = 8'h5D;
   localparam int         PDOWN_BIT     = 1;
   localparam logic [7:0] ADDR_MASK_LOS = 8'h64;
   localparam logic [7:0] ADDR_MASK_TXF = 8'h65;
   localparam logic [7:0] ADDR_MASK_RDY = 8'h66;
   localparam logic [7:0] ADDR_PAGE     = 8'h7F;
   localparam logic [7:0] USER_PAGE     = 8'h02;
   localparam int         UPPER_BIT     = 7;
   localparam int         USER_DEPTH    = 128;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic scl;
      logic sda;
      logic selN;
      logic rstN;
      logic lowPower;
   } mmcs_pins_s;

   localparam mmcs_pins_s PINS_IDLE = '{scl: 1'h1, sda: 1'h1, selN: 1'h1, rstN: 1'h1,
                                        lowPower: 1'h0};

   typedef struct packed {
      logic [3:0] los;
      logic [3:0] txFault;
   } mmcs_cond_s;

   typedef enum logic [2:0] {
      I2C_IDLE = 3'h0,
      I2C_ADDR = 3'h1,
      I2C_AACK = 3'h3,
      I2C_WR   = 3'h2,
      I2C_WACK = 3'h6,
      I2C_RD   = 3'h7,
      I2C_RACK = 3'h5
   } mmcs_i2c_e;

endpackage

// ===== mmcs_pin_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to clk_sys
// Notes:   output changes only when stages two and three agree

`timescale 1ns/1ps
`default_nettype none

module mmcs_pin_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] filt;
   } mmcs_sync_s;

   mmcs_sync_s st;
   mmcs_sync_s next_st;

   always_comb
   begin
      next_st    = st;
      next_st.s1 = din;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // s1 is read by s2 only
      for (int i = 0; i < WIDTH; i++)
      begin
         if (st.s2[i] == st.s3[i])
         begin
            next_st.filt[i] = st.s3[i];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
      end
      else if (ce)
      begin
         st <= next_st;
      end
   end

   assign dout = st.filt;

endmodule

`default_nettype wire

// ===== mmcs_timer.sv
// Purpose: saturating counter flagging a cycle count
// Assumes: LIMIT fits in WIDTH bits
// Notes:   clear has priority over counting

`timescale 1ns/1ps
`default_nettype none

module mmcs_timer #(
   parameter int LIMIT = 16,
   parameter int WIDTH = $clog2(LIMIT + 1)
) (
   input  wire logic clk_sys,
   input  wire logic arst_n,
   input  wire logic ce,
   input  wire logic clear,
   output logic      expired
);

   localparam logic [WIDTH-1:0] LIMIT_W = LIMIT[WIDTH-1:0];

   typedef struct packed {
      logic [WIDTH-1:0] cnt;
   } mmcs_timer_s;

   mmcs_timer_s st;
   mmcs_timer_s next_st;

   always_comb
   begin
      next_st = st;
      if (clear)
      begin
         next_st.cnt = '0;
      end
      else if (st.cnt != LIMIT_W)
      begin
         next_st.cnt = st.cnt + {{(WIDTH-1){1'h0}}, 1'h1};
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st <= '0;
      end
      else if (ce)
      begin
         st <= next_st;
      end
   end

   assign expired = (st.cnt == LIMIT_W);

endmodule

`default_nettype wire

// ===== mmcs_mgmt_ctrl.sv
// Purpose: management control and status of a pluggable module: init, reset
//          filter, select-gated two-wire slave, flags, interrupt
// Assumes: arst_n is the power-on reset; condition inputs are on clk_sys
// Notes:   two-wire pins are oversampled; scl must be far slower than clk_sys

`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R1] fully functional within 2000 ms of start
// [R2] reset only after low beyond 2 us
// [R3] bus answers within 2000 ms of power-on
// [R4] init clears not-ready bit, asserts interrupt
// [R5] functional within 2000 ms after reset release
// [R6] fully functional equals not-ready bit cleared
// [R7] low power pin enters low power quickly
// [R8] condition drives interrupt low within 200 ms
// [R9] read clear releases interrupt within 500 us
// [R10] flags clear on read, after stop
// [R11] mask and power writes act promptly
// [R12] loss of signal sets flag, interrupt
// [R13] any condition sets its flag, interrupt
// [R14] set mask stops flag's interrupt
// [R15] cleared mask resumes flag's interrupt
// [R16] selected module answers bus within 100 us
// [R17] deselected module stops answering within 100 us
// [R18] power-down bit enters low power
// [R19] power-down clear returns to full function
// [R20] page 2 is free user storage
// [R21] slave address is 1010000
// [R22] interrupt held while unmasked flag set
// [R23] short reset pulses are ignored
module mmcs_mgmt_ctrl
   import mmcs_pkg::*;
#(
   parameter int INIT_CYCLES = INIT_DEFAULT_CYCLES
) (
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   input  wire logic       ce,
   input  wire logic       sclIn,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOe,
   input  wire logic       moduleSelectN,
   input  wire logic       moduleResetN,
   input  wire logic       lowPowerPin,
   input  wire mmcs_cond_s condIn,
   output logic            interruptN,
   output logic            modulePresentN,
   output logic            lowPowerOut,
   output logic            dataNotReady,
   output logic            fullyFunctional
);

   // ==========================================================
   // state
   typedef struct packed {
      mmcs_i2c_e                  state;
      logic [3:0]                 bitCnt;
      logic [7:0]                 shift;
      logic                       isRead;
      logic                       ackPhase;
      logic                       ptrLoaded;
      logic [7:0]                 ptr;
      logic                       sdaDrive;
      logic                       sclPrev;
      logic                       sdaPrev;
      logic [3:0]                 los;
      logic [3:0]                 txFault;
      logic                       ready;
      logic                       clrLos;
      logic                       clrTxf;
      logic                       clrRdy;
      logic [3:0]                 maskLos;
      logic [3:0]                 maskTxf;
      logic                       maskRdy;
      logic [7:0]                 ctrl;
      logic [7:0]                 page;
      logic                       initDonePrev;
      logic                       dnr;
      logic                       intPending;
      logic                       lowPower;
      logic [USER_DEPTH-1:0][7:0] userMem;
   } mmcs_state_s;

   mmcs_state_s st;
   mmcs_state_s next_st;
   mmcs_pins_s  pin;
   logic        rstHeld;
   logic        initDone;
   logic        inReset;
   logic        active;
   logic        sclRise;
   logic        sclFall;
   logic        startCond;
   logic        stopCond;
   logic [7:0]  inByte;
   logic [7:0]  rdByte;
   logic        doLoad;

   // ==========================================================
   // map access
   function automatic logic [7:0] mmcs_read(input mmcs_state_s s, input logic [7:0] a);
      logic [7:0] r;
      r = 8'h00;
      if (a[UPPER_BIT])
      begin
         // [R20] user page store
         if (s.page == USER_PAGE)
         begin
            r = s.userMem[a[6:0]];
         end
      end
      else
      begin
         case (a)
            ADDR_STATUS:   r[DNR_BIT] = s.dnr;
            ADDR_FLAG_LOS: r = {4'h0, s.los};
            ADDR_FLAG_TXF: r = {4'h0, s.txFault};
            ADDR_FLAG_RDY: r = {7'h00, s.ready};
            ADDR_CTRL_PWR: r = s.ctrl;
            ADDR_MASK_LOS: r = {4'h0, s.maskLos};
            ADDR_MASK_TXF: r = {4'h0, s.maskTxf};
            ADDR_MASK_RDY: r = {7'h00, s.maskRdy};
            ADDR_PAGE:     r = s.page;
            default:       r = 8'h00;
         endcase
      end
      return r;
   endfunction

   function automatic mmcs_state_s mmcs_write(input mmcs_state_s s, input logic [7:0] a,
                                              input logic [7:0] d);
      mmcs_state_s r;
      r = s;
      if (a[UPPER_BIT])
      begin
         // [R20] user page store
         if (s.page == USER_PAGE)
         begin
            r.userMem[a[6:0]] = d;
         end
      end
      else
      begin
         // [R11] writes act at once
         case (a)
            ADDR_CTRL_PWR: r.ctrl    = d;
            ADDR_MASK_LOS: r.maskLos = d[3:0];
            ADDR_MASK_TXF: r.maskTxf = d[3:0];
            ADDR_MASK_RDY: r.maskRdy = d[0];
            ADDR_PAGE:     r.page    = d;
            default:       r.page    = s.page;
         endcase
      end
      return r;
   endfunction

   // ==========================================================
   // pin conditioning and timers
   mmcs_pin_sync #(
      .WIDTH     (5),
      .RESET_VAL (PINS_IDLE)
   ) u_pin_sync (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .ce      (ce),
      .din     ({sclIn, sdaIn, moduleSelectN, moduleResetN, lowPowerPin}),
      .dout    (pin)
   );

   // [R2] low width filter
   mmcs_timer #(
      .LIMIT (RESET_HOLD_CYCLES)
   ) u_reset_timer (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .ce      (ce),
      .clear   (pin.rstN),
      .expired (rstHeld)
   );

   // [R1] init delay
   mmcs_timer #(
      .LIMIT (INIT_CYCLES)
   ) u_init_timer (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .ce      (ce),
      .clear   (inReset),
      .expired (initDone)
   );

   // [R23] glitch never clears init timer
   assign inReset   = rstHeld;
   // [R16] select gates slave
   assign active    = !pin.selN && initDone && !inReset;
   assign sclRise   = pin.scl && !st.sclPrev;
   assign sclFall   = !pin.scl && st.sclPrev;
   assign startCond = pin.scl && st.sclPrev && st.sdaPrev && !pin.sda;
   assign stopCond  = pin.scl && st.sclPrev && !st.sdaPrev && pin.sda;
   assign inByte    = {st.shift[6:0], pin.sda};
   assign rdByte    = mmcs_read(st, st.ptr);

   // ==========================================================
   // next state
   always_comb
   begin
      next_st         = st;
      doLoad          = 1'h0;
      next_st.sclPrev = pin.scl;
      next_st.sdaPrev = pin.sda;
      next_st.initDonePrev = initDone;

      // [R10] clear after stop; set wins
      // [R12] loss of signal latch
      next_st.los     = (st.los & ~{4{stopCond & st.clrLos}}) | condIn.los;
      // [R13] flag latch
      next_st.txFault = (st.txFault & ~{4{stopCond & st.clrTxf}}) | condIn.txFault;
      // [R4] ready event flag
      next_st.ready   = (st.ready & ~(stopCond & st.clrRdy)) | (initDone & !st.initDonePrev);
      if (stopCond)
      begin
         next_st.clrLos = 1'h0;
         next_st.clrTxf = 1'h0;
         next_st.clrRdy = 1'h0;
      end

      // [R17] deselect drops slave
      if (!active)
      begin
         next_st.state    = I2C_IDLE;
         next_st.sdaDrive = 1'h0;
         next_st.ackPhase = 1'h0;
      end
      else if (startCond)
      begin
         next_st.state     = I2C_ADDR;
         next_st.bitCnt    = 4'h0;
         next_st.ptrLoaded = 1'h0;
         next_st.sdaDrive  = 1'h0;
         next_st.ackPhase  = 1'h0;
      end
      else if (stopCond)
      begin
         next_st.state    = I2C_IDLE;
         next_st.sdaDrive = 1'h0;
      end
      else
      begin
         case (st.state)
            I2C_IDLE:
            begin
               next_st.sdaDrive = 1'h0;
            end
            I2C_ADDR:
            begin
               if (sclRise)
               begin
                  next_st.shift  = inByte;
                  next_st.bitCnt = st.bitCnt + 4'h1;
                  if (st.bitCnt == 4'h7)
                  begin
                     next_st.bitCnt = 4'h0;
                     // [R21] address match
                     if (inByte[7:1] == DEV_ADDR)
                     begin
                        next_st.state    = I2C_AACK;
                        next_st.isRead   = inByte[0];
                        next_st.ackPhase = 1'h0;
                     end
                     else
                     begin
                        next_st.state = I2C_IDLE;
                     end
                  end
               end
            end
            I2C_AACK, I2C_WACK:
            begin
               if (sclFall)
               begin
                  if (!st.ackPhase)
                  begin
                     next_st.sdaDrive = 1'h1;
                     next_st.ackPhase = 1'h1;
                  end
                  else
                  begin
                     next_st.sdaDrive = 1'h0;
                     next_st.ackPhase = 1'h0;
                     next_st.bitCnt   = 4'h0;
                     if (st.state == I2C_AACK && st.isRead)
                     begin
                        doLoad = 1'h1;
                     end
                     else
                     begin
                        next_st.state = I2C_WR;
                     end
                  end
               end
            end
            I2C_WR:
            begin
               if (sclRise)
               begin
                  next_st.shift  = inByte;
                  next_st.bitCnt = st.bitCnt + 4'h1;
                  if (st.bitCnt == 4'h7)
                  begin
                     if (!st.ptrLoaded)
                     begin
                        next_st.ptr       = inByte;
                        next_st.ptrLoaded = 1'h1;
                     end
                     else
                     begin
                        next_st     = mmcs_write(next_st, st.ptr, inByte);
                        next_st.ptr = st.ptr + 8'h01;
                     end
                     next_st.state    = I2C_WACK;
                     next_st.bitCnt   = 4'h0;
                     next_st.ackPhase = 1'h0;
                  end
               end
            end
            I2C_RD:
            begin
               if (sclFall)
               begin
                  if (st.bitCnt == 4'h8)
                  begin
                     // free line for master ack
                     next_st.sdaDrive = 1'h0;
                     next_st.ackPhase = 1'h0;
                     next_st.state    = I2C_RACK;
                  end
                  else
                  begin
                     next_st.sdaDrive = !st.shift[7];
                     next_st.shift    = {st.shift[6:0], 1'h0};
                     next_st.bitCnt   = st.bitCnt + 4'h1;
                  end
               end
            end
            I2C_RACK:
            begin
               if (sclRise)
               begin
                  next_st.ackPhase = !pin.sda;
               end
               else if (sclFall)
               begin
                  next_st.ackPhase = 1'h0;
                  if (st.ackPhase)
                  begin
                     doLoad = 1'h1;
                  end
                  else
                  begin
                     // master declined, wait for stop
                     next_st.state = I2C_IDLE;
                  end
               end
            end
            default:
            begin
               next_st.state    = I2C_IDLE;
               next_st.sdaDrive = 1'h0;
            end
         endcase
      end

      if (doLoad)
      begin
         next_st.state    = I2C_RD;
         next_st.sdaDrive = !rdByte[7];
         next_st.shift    = {rdByte[6:0], 1'h0};
         next_st.bitCnt   = 4'h1;
         next_st.ptr      = st.ptr + 8'h01;
         // [R10] mark flag byte read
         if (st.ptr == ADDR_FLAG_LOS)
         begin
            next_st.clrLos = 1'h1;
         end
         if (st.ptr == ADDR_FLAG_TXF)
         begin
            next_st.clrTxf = 1'h1;
         end
         if (st.ptr == ADDR_FLAG_RDY)
         begin
            next_st.clrRdy = 1'h1;
         end
      end

      // user page survives module reset
      if (inReset)
      begin
         next_st.state    = I2C_IDLE;
         next_st.sdaDrive = 1'h0;
         next_st.los      = 4'h0;
         next_st.txFault  = 4'h0;
         next_st.ready    = 1'h0;
         next_st.clrLos   = 1'h0;
         next_st.clrTxf   = 1'h0;
         next_st.clrRdy   = 1'h0;
         next_st.maskLos  = 4'h0;
         next_st.maskTxf  = 4'h0;
         next_st.maskRdy  = 1'h0;
         next_st.ctrl     = 8'h00;
         next_st.page     = 8'h00;
      end

      // [R6] not-ready tracks init
      next_st.dnr = !initDone || inReset;
      // [R22] any unmasked flag holds
      // [R14] masked flags excluded
      // [R15] unmasked flags included
      next_st.intPending = |(st.los & ~st.maskLos) | |(st.txFault & ~st.maskTxf) |
                           (st.ready & !st.maskRdy);
      // [R7] pin low power
      // [R18] power-down bit
      // [R19] clearing restores function
      next_st.lowPower = pin.lowPower | st.ctrl[PDOWN_BIT];
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st         <= '0;
         st.state   <= I2C_IDLE;
         st.sclPrev <= 1'h1;
         st.sdaPrev <= 1'h1;
         st.dnr     <= 1'h1;
      end
      else if (ce)
      begin
         st <= next_st;
      end
   end

   // ==========================================================
   // outputs
   // [R8] interrupt follows pending
   // [R9] released after clear
   assign interruptN      = !st.intPending;
   // [R3] slave open drain
   assign sdaOut          = 1'h0;
   assign sdaOe           = st.sdaDrive;
   assign modulePresentN  = 1'h0;
   assign lowPowerOut     = st.lowPower;
   assign dataNotReady    = st.dnr;
   // [R5] function after release
   assign fullyFunctional = !st.dnr;

endmodule

`default_nettype wire

// ===== mmcs_mgmt_ctrl_checker.sv
// Purpose: port assertions for the management control block
// Assumes: bound to the top module, ce held high
// Notes:   pin paths add a few cycles, so bounds carry margin

`timescale 1ns/1ps
`default_nettype none

module mmcs_mgmt_ctrl_checker
   import mmcs_pkg::*;
#(
   parameter int INIT_CYCLES = INIT_DEFAULT_CYCLES
) (
   input wire logic       clk_sys,
   input wire logic       arst_n,
   input wire logic       sclIn,
   input wire logic       sdaOe,
   input wire logic       moduleSelectN,
   input wire logic       moduleResetN,
   input wire logic       lowPowerPin,
   input wire logic       interruptN,
   input wire logic       lowPowerOut,
   input wire logic       dataNotReady,
   input wire logic       fullyFunctional
);
   // ==========================================================
   // helper counters
   localparam int INIT_MAX = INIT_CYCLES + 12;
   logic [7:0]  lowCnt;
   logic [15:0] waitCnt;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lowCnt  <= 8'h00;
         waitCnt <= 16'h0000;
      end
      else
      begin
         lowCnt  <= moduleResetN ? 8'h00 : lowCnt + 8'(lowCnt != 8'hFF);
         waitCnt <= (dataNotReady && moduleResetN) ? waitCnt + 16'h0001 : 16'h0000;
      end
   end

   // ==========================================================
   // assertions
   a_ready_mirror: assert property (fullyFunctional == !dataNotReady)
      else $error("ready output wrong");
   a_init_bound: assert property (waitCnt <= 16'(INIT_MAX))
      else $error("init too long");
   a_ready_irq: assert property ($fell(dataNotReady) |-> ##[1:4] !interruptN)
      else $error("no interrupt after init");
   a_irq_release: assert property ($rose(interruptN) |-> sclIn)
      else $error("interrupt released outside a stop");
   a_lp_pin: assert property (lowPowerPin [*8] |-> lowPowerOut)
      else $error("low power pin ignored");
   a_desel_quiet: assert property (moduleSelectN [*8] |-> !sdaOe)
      else $error("deselected module drives data");
   a_long_reset: assert property (lowCnt > 8'h5A |-> dataNotReady)
      else $error("long reset not taken");
   a_short_pulse: assert property (
      $rose(moduleResetN) && lowCnt < 8'h46 && !dataNotReady |-> !dataNotReady [*8])
      else $error("short reset pulse taken");
endmodule

bind mmcs_mgmt_ctrl mmcs_mgmt_ctrl_checker #(
   .INIT_CYCLES(INIT_CYCLES)
) u_checker (
   .clk_sys, .arst_n, .sclIn, .sdaOe, .moduleSelectN, .moduleResetN, .lowPowerPin,
   .interruptN, .lowPowerOut, .dataNotReady, .fullyFunctional
);

`default_nettype wire

// ===== mmcs_host_model.sv
// Purpose: host side of the two-wire bus, bit-banged
// Assumes: sda pulled up when released
// Notes:   scl is slow against clk_sys so the pin filters can follow

`timescale 1ns/1ps
`default_nettype none

module mmcs_host_model #(
   parameter int HALF = 10
) (
   input  wire logic clk_sys,
   input  wire logic sda,
   output logic      scl,
   output logic      sdaLow
);
   initial
   begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end

   // change, then hold HALF clk_sys cycles, a third of a bus clock
   task automatic step(input logic l, input logic c);
      sdaLow = l;
      scl = c;
      repeat (HALF) @(negedge clk_sys);
   endtask

   // data only moves while scl is low, so no false start or stop
   task automatic start();
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
   endtask

   task automatic stop();
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
   endtask

   // eight bits then a released acknowledge slot
   task automatic xbyte(input logic [7:0] d, input logic useAck, inout logic ok,
                        output logic [7:0] q);
      logic [8:0] got;
      for (int i = 8; i >= 0; i--)
      begin
         step(i > 0 && !d[i-1], 1'b0);
         step(i > 0 && !d[i-1], 1'b1);
         got[i] = sda;
         step(i > 0 && !d[i-1], 1'b0);
      end
      q = got[8:1];
      if (useAck)
         ok = ok & !got[0];
   endtask

   task automatic head(input logic [7:0] a, output logic ok);
      logic [7:0] q;
      ok = 1'b1;
      start();
      xbyte(8'hA0, 1'b1, ok, q);
      xbyte(a, 1'b1, ok, q);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
      logic [7:0] q;
      head(a, ok);
      xbyte(d, 1'b1, ok, q);
      stop();
   endtask

   task automatic rd(input logic [7:0] a, output logic [8:0] r);
      logic       ok;
      logic [7:0] q;
      head(a, ok);
      start();
      xbyte(8'hA1, 1'b1, ok, q);
      xbyte(8'hFF, 1'b0, ok, q);
      stop();
      r = {ok, q};
   endtask
endmodule

`default_nettype wire

// ===== mmcs_mgmt_ctrl_tb.sv
// Purpose: self-checking bench of the management control block
// Assumes: short init count, host model on the two-wire bus
// Notes:   driver queues expectations, a watcher compares

`timescale 1ns/1ps
`default_nettype none

module mmcs_mgmt_ctrl_tb
   import mmcs_pkg::*;
   ();
   localparam int INIT = 16;
   logic       clk_sys = 1'b0;
   logic       arst_n = 1'b0;
   logic       moduleSelectN = 1'b0;
   logic       moduleResetN = 1'b1;
   logic       lowPowerPin = 1'b0;
   mmcs_cond_s condIn = '0;
   int         mismatches = 0;
   int         samples_checked = 0;
   int         seed = 49;
   logic [8:0] expQ[$];
   logic [8:0] obs;
   logic [8:0] r;
   logic [7:0] v;
   logic       ok;
   event       seen;
   wire logic  scl, sdaLow, sda, sdaOut, sdaOe, interruptN, modulePresentN;
   wire logic  lowPowerOut, dataNotReady, fullyFunctional;
   wire logic [8:0] pins = {4'h0, modulePresentN, interruptN, dataNotReady, fullyFunctional,
                            lowPowerOut};

   assign sda = !(sdaLow | (sdaOe & !sdaOut));
   always #12.5 clk_sys = !clk_sys;

   mmcs_mgmt_ctrl #(
      .INIT_CYCLES(INIT)
   ) u_dut (
      .clk_sys, .arst_n, .ce(1'b1), .sclIn(scl), .sdaIn(sda), .sdaOut, .sdaOe,
      .moduleSelectN, .moduleResetN, .lowPowerPin, .condIn, .interruptN,
      .modulePresentN, .lowPowerOut, .dataNotReady, .fullyFunctional
   );

   mmcs_host_model u_host (
      .clk_sys, .sda, .scl, .sdaLow
   );

   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic chk(input logic [8:0] e, input logic [8:0] o);
      expQ.push_back(e);
      obs = o;
      ->seen;
      idle(1);
   endtask

   always @(seen)
   begin
      samples_checked++;
      if (obs !== expQ[0])
         $display("unexpected at %0t: got %h want %h", $time, obs, expQ[0]);
      if (obs !== expQ[0])
         mismatches++;
      void'(expQ.pop_front());
   end

   task automatic results();
      if (mismatches == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      idle(5);
      arst_n = 1'b1;
      idle(INIT + 30);
      chk(9'h002, pins);
      u_host.rd(8'h02, r);
      chk(9'h100, r);
      u_host.rd(8'h05, r);
      idle(8);
      chk(9'h101, r);
      chk(9'h00A, pins);
      // ==========================================================
      // random flags, cleared per byte
      v = 8'($random(seed)) | 8'h81;
      condIn = v;
      idle(6);
      chk(9'h002, pins);
      condIn = '0;
      u_host.rd(8'h03, r);
      chk({5'h10, v[7:4]}, r);
      chk(9'h002, pins);
      u_host.rd(8'h04, r);
      idle(8);
      chk({5'h10, v[3:0]}, r);
      chk(9'h00A, pins);
      // ==========================================================
      // masking, low power, select
      u_host.wr(8'h64, 8'h0F, ok);
      condIn = 8'h20;
      idle(6);
      chk(9'h10A, {ok, pins[7:0]});
      u_host.wr(8'h64, 8'h00, ok);
      idle(6);
      chk(9'h102, {ok, pins[7:0]});
      condIn = '0;
      u_host.rd(8'h03, r);
      idle(8);
      chk(9'h00A, pins);
      lowPowerPin = 1'b1;
      idle(10);
      chk(9'h00B, pins);
      lowPowerPin = 1'b0;
      u_host.wr(8'h5D, 8'h02, ok);
      idle(4);
      chk(9'h10B, {ok, pins[7:0]});
      u_host.wr(8'h5D, 8'h00, ok);
      idle(4);
      chk(9'h10A, {ok, pins[7:0]});
      moduleSelectN = 1'b1;
      idle(8);
      u_host.rd(8'h02, r);
      chk(9'h0FF, r);
      moduleSelectN = 1'b0;
      idle(8);
      u_host.rd(8'h02, r);
      chk(9'h100, r);
      // ==========================================================
      // user page, module resets
      v = 8'($random(seed));
      u_host.wr(8'h7F, 8'h02, ok);
      u_host.wr(8'h80, v, ok);
      u_host.rd(8'h80, r);
      chk({1'b1, v}, r);
      u_host.wr(8'h7F, 8'h00, ok);
      u_host.rd(8'h80, r);
      chk(9'h100, r);
      moduleResetN = 1'b0;
      idle(60);
      moduleResetN = 1'b1;
      idle(10);
      chk(9'h00A, pins);
      moduleResetN = 1'b0;
      idle(100);
      chk(9'h00C, pins);
      moduleResetN = 1'b1;
      idle(INIT + 20);
      chk(9'h002, pins);
      results();
   end

   initial
   begin
      repeat (40000) @(posedge clk_sys);
      mismatches++;
      results();
   end
endmodule

`default_nettype wire
